// File: oam_delay_generic_seq_engine.v
// Purpose: oam endpoint engine lookup for delay, generic, link trace and
//          test sequence numbering frames
// Assumes: one lookup per cycle from the same-clock pipeline; result one
//          cycle later; registers over a plain strobe port
// Notes:   sticky bits clear on write-one, a same-cycle event wins
//
// Summary of operation
// - tx request: forward tx stamp, count
// - rx request: flag, forward rx stamp, count, copy
// - loop enabled: inject reply per received request
// - tx reply: backward tx stamp, count
// - rx reply: flag, backward rx stamp, count, copy
// - per-type oam and loss count enables
// - external stamping leaves stamp fields untouched
// - one-way disabled: statistics only
// - tx one-way: forward tx stamp, shared count
// - rx one-way: flag, forward rx stamp, copy
// - one-way oam and loss count enables
// - generic/unknown never modified, tx no action
// - rx generic/unknown: sticky, optional extract queues
// - generic mask and unknown enable for counts
// - own level blocked unless generic pass
// - link trace valid by level and dmac
// - link trace copy, queue, count enables
// - link trace rx sets its flag
// - no sequence numbering with test/loopback
// - initiator or responder; msg/rsp by direction
// - responder checks number, flags error
// - request/reply hw enables, else statistics only
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "oam_delay_generic_seq_engine_defs.vh"

module oam_delay_generic_seq_engine (
   input  wire                 clock,
   input  wire                 nrst,
   input  wire                 clk_en,
   input  wire [`ADDR_W-1:0]   reg_addr,
   input  wire [31:0]          reg_wdata,
   input  wire                 reg_wr,
   input  wire                 reg_rd,
   output reg  [31:0]          reg_rdata,
   input  wire                 lk_valid,
   input  wire                 lk_rx,
   input  wire [3:0]           lk_type,
   input  wire [2:0]           lk_gen_idx,
   input  wire                 lk_same_level,
   input  wire                 lk_dmac_ok,
   input  wire [31:0]          lk_seq_no,
   input  wire [`TS_W-1:0]     lk_timestamp,
   output reg                  res_valid,
   output reg                  res_discard,
   output reg                  res_ts_write,
   output reg  [1:0]           res_ts_field,
   output reg  [`TS_W-1:0]     res_ts_value,
   output reg                  res_extract,
   output reg  [`Q_W-1:0]      res_queue,
   output reg                  res_loop_reply,
   output reg                  res_oam_count,
   output reg                  res_data_count,
   output reg                  res_is_msg,
   output reg                  res_is_rsp,
   output reg                  res_seq_write,
   output reg  [31:0]          res_seq_value,
   output reg                  res_seq_error
);

   // enable bit for a pdu type out of a per-type layout
   function type_bit;
      input [`EN_W-1:0] en;
      input [3:0]       t;
      input [2:0]       g;
      begin
         case (t)
            `PDU_REQ: type_bit = en[`EN_REQ];
            `PDU_REP: type_bit = en[`EN_REP];
            `PDU_ONE: type_bit = en[`EN_ONE];
            `PDU_UNK: type_bit = en[`EN_UNK];
            `PDU_LTM: type_bit = en[`EN_LTM];
            `PDU_LTR: type_bit = en[`EN_LTR];
            `PDU_GEN: type_bit = en[`GEN_LSB + g];
            default:  type_bit = 1'b0;
         endcase
      end
   endfunction

   reg [`CTRL_W-1:0]    ctrl_r;
   reg [`EN_W-1:0]      oam_cnt_en_r;
   reg [`EN_W-1:0]      data_cnt_en_r;
   reg [`EN_W-1:0]      copy_en_r;
   reg [11:0]           queues_r;
   reg [`GEN_N-1:0]     pass_r;
   reg [`EN_W-1:0]      sticky_r;
   reg [31:0]           req_tx_cnt_r;
   reg [31:0]           req_rx_cnt_r;
   reg [31:0]           rep_tx_cnt_r;
   reg [31:0]           rep_rx_cnt_r;
   reg [31:0]           seq_tx_id_r;
   reg [31:0]           seq_rx_id_r;
   reg [31:0]           seq_err_cnt_r;

   reg [`EN_W-1:0]      sticky_set;
   reg                  discard_nxt;
   reg                  ts_write_nxt;
   reg [1:0]            ts_field_nxt;
   reg                  extract_nxt;
   reg [`Q_W-1:0]       queue_nxt;
   reg                  loop_nxt;
   reg                  oam_cnt_nxt;
   reg                  data_cnt_nxt;
   reg                  msg_nxt;
   reg                  rsp_nxt;
   reg                  seq_write_nxt;
   reg                  seq_err_nxt;
   reg                  inc_req_tx;
   reg                  inc_req_rx;
   reg                  inc_rep_tx;
   reg                  inc_rep_rx;
   reg                  seq_rx_upd;
   reg [31:0]           rdata_nxt;

   wire        wr_sel_ctrl = reg_wr && (reg_addr == `REG_CTRL);
   wire        ext_ts      = ctrl_r[`CTRL_EXT_TS];
   wire        seq_resp    = ctrl_r[`CTRL_SEQ_RESP];
   wire        seq_on      = ctrl_r[`CTRL_SEQ_EN] &
                             ~ctrl_r[`CTRL_LB_TST_USE];
   wire        is_oam      = (lk_type != `PDU_NONE) && (lk_type != `PDU_SEQ);
   // own-level y.1731 pdu with good dmac is processed here
   wire        oam_ok      = lk_valid && is_oam && lk_same_level && lk_dmac_ok;
   wire        seq_ok      = lk_valid && (lk_type == `PDU_SEQ) && seq_on &&
                             lk_dmac_ok;
   wire [31:0] seq_expect  = seq_rx_id_r + 32'h0000_0001;
   wire        gen_pass    = (lk_type == `PDU_GEN) && pass_r[lk_gen_idx];

   always @* begin
      sticky_set    = {`EN_W{1'b0}};
      discard_nxt   = 1'b0;
      ts_write_nxt  = 1'b0;
      ts_field_nxt  = `TSF_TX_FWD;
      extract_nxt   = 1'b0;
      queue_nxt     = queues_r[`Q_DEF_LSB +: `Q_W];
      loop_nxt      = 1'b0;
      oam_cnt_nxt   = 1'b0;
      data_cnt_nxt  = 1'b0;
      msg_nxt       = 1'b0;
      rsp_nxt       = 1'b0;
      seq_write_nxt = 1'b0;
      seq_err_nxt   = 1'b0;
      inc_req_tx    = 1'b0;
      inc_req_rx    = 1'b0;
      inc_rep_tx    = 1'b0;
      inc_rep_rx    = 1'b0;
      seq_rx_upd    = 1'b0;
      if (oam_ok) begin
         discard_nxt  = ~gen_pass;
         oam_cnt_nxt  = type_bit(oam_cnt_en_r, lk_type, lk_gen_idx);
         data_cnt_nxt = type_bit(data_cnt_en_r, lk_type, lk_gen_idx);
         if (lk_rx) begin
            extract_nxt = type_bit(copy_en_r, lk_type, lk_gen_idx);
            case (lk_type)
               `PDU_REQ: begin
                  sticky_set[`EN_REQ] = 1'b1;
                  inc_req_rx          = 1'b1;
                  ts_write_nxt        = ctrl_r[`CTRL_REQ_HW] & ~ext_ts;
                  ts_field_nxt        = `TSF_RX_FWD;
                  loop_nxt            = ctrl_r[`CTRL_LOOP];
               end
               `PDU_REP: begin
                  sticky_set[`EN_REP] = 1'b1;
                  inc_rep_rx          = 1'b1;
                  ts_write_nxt        = ctrl_r[`CTRL_REP_HW] & ~ext_ts;
                  ts_field_nxt        = `TSF_RX_BWD;
               end
               `PDU_ONE: begin
                  sticky_set[`EN_ONE] = 1'b1;
                  inc_rep_rx          = 1'b1;
                  ts_write_nxt        = ctrl_r[`CTRL_ONE_HW] & ~ext_ts;
                  ts_field_nxt        = `TSF_RX_FWD;
               end
               `PDU_LTM: begin
                  sticky_set[`EN_LTM] = 1'b1;
                  queue_nxt           = queues_r[`Q_LT_LSB +: `Q_W];
               end
               `PDU_LTR: begin
                  sticky_set[`EN_LTR] = 1'b1;
                  queue_nxt           = queues_r[`Q_LT_LSB +: `Q_W];
               end
               `PDU_GEN: begin
                  sticky_set[`GEN_LSB + lk_gen_idx] = 1'b1;
                  queue_nxt = queues_r[`Q_GEN_LSB +: `Q_W];
               end
               `PDU_UNK: begin
                  sticky_set[`EN_UNK] = 1'b1;
               end
               default: begin
                  sticky_set = {`EN_W{1'b0}};
               end
            endcase
         end else begin
            // generic, unknown and link trace take no tx action
            case (lk_type)
               `PDU_REQ: begin
                  inc_req_tx   = 1'b1;
                  ts_write_nxt = ctrl_r[`CTRL_REQ_HW] & ~ext_ts;
                  ts_field_nxt = `TSF_TX_FWD;
               end
               `PDU_REP: begin
                  inc_rep_tx   = 1'b1;
                  ts_write_nxt = ctrl_r[`CTRL_REP_HW] & ~ext_ts;
                  ts_field_nxt = `TSF_TX_BWD;
               end
               `PDU_ONE: begin
                  inc_req_tx   = 1'b1;
                  ts_write_nxt = ctrl_r[`CTRL_ONE_HW] & ~ext_ts;
                  ts_field_nxt = `TSF_TX_FWD;
               end
               default: begin
                  ts_write_nxt = 1'b0;
               end
            endcase
         end
      end else if (seq_ok) begin
         // message on initiator tx / responder rx, else response
         msg_nxt = lk_rx == seq_resp;
         rsp_nxt = lk_rx != seq_resp;
         if (lk_rx) begin
            sticky_set[`STK_SEQ_RX] = 1'b1;
            seq_rx_upd  = 1'b1;
            seq_err_nxt = lk_seq_no != seq_expect;
            sticky_set[`STK_SEQ_ERR] = seq_err_nxt;
            // the responder flags the frame without a checksum check
            seq_write_nxt = seq_resp & seq_err_nxt;
         end else begin
            seq_write_nxt = ~seq_resp;
         end
      end
   end

   // register read mux
   always @* begin
      case (reg_addr)
         `REG_CTRL:        rdata_nxt = {24'h00_0000, ctrl_r};
         `REG_OAM_CNT_EN:  rdata_nxt = {16'h0000, oam_cnt_en_r};
         `REG_DATA_CNT_EN: rdata_nxt = {16'h0000, data_cnt_en_r};
         `REG_COPY_EN:     rdata_nxt = {16'h0000, copy_en_r};
         `REG_QUEUES:      rdata_nxt = {20'h0_0000, queues_r};
         `REG_PASS:        rdata_nxt = {24'h00_0000, pass_r};
         `REG_STICKY:      rdata_nxt = {16'h0000, sticky_r};
         `REG_REQ_TX_CNT:  rdata_nxt = req_tx_cnt_r;
         `REG_REQ_RX_CNT:  rdata_nxt = req_rx_cnt_r;
         `REG_REP_TX_CNT:  rdata_nxt = rep_tx_cnt_r;
         `REG_REP_RX_CNT:  rdata_nxt = rep_rx_cnt_r;
         `REG_SEQ_TX_ID:   rdata_nxt = seq_tx_id_r;
         `REG_SEQ_RX_ID:   rdata_nxt = seq_rx_id_r;
         `REG_SEQ_ERR_CNT: rdata_nxt = seq_err_cnt_r;
         default:          rdata_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_r        <= `RST_CTRL;
         oam_cnt_en_r  <= `RST_EN;
         data_cnt_en_r <= `RST_EN;
         copy_en_r     <= `RST_EN;
         queues_r      <= `RST_QUEUES;
         pass_r        <= `RST_PASS;
         sticky_r      <= `RST_EN;
         req_tx_cnt_r  <= `RST_CNT;
         req_rx_cnt_r  <= `RST_CNT;
         rep_tx_cnt_r  <= `RST_CNT;
         rep_rx_cnt_r  <= `RST_CNT;
         seq_tx_id_r   <= `RST_CNT;
         seq_rx_id_r   <= `RST_CNT;
         seq_err_cnt_r <= `RST_CNT;
         reg_rdata     <= 32'h0000_0000;
      end else if (clk_en) begin
         if (wr_sel_ctrl) begin
            // role is a single bit, so both roles at once cannot be set
            ctrl_r <= reg_wdata[`CTRL_W-1:0];
         end
         if (reg_wr && (reg_addr == `REG_OAM_CNT_EN)) begin
            oam_cnt_en_r <= reg_wdata[`EN_W-1:0];
         end
         if (reg_wr && (reg_addr == `REG_DATA_CNT_EN)) begin
            data_cnt_en_r <= reg_wdata[`EN_W-1:0];
         end
         if (reg_wr && (reg_addr == `REG_COPY_EN)) begin
            copy_en_r <= reg_wdata[`EN_W-1:0];
         end
         if (reg_wr && (reg_addr == `REG_QUEUES)) begin
            queues_r <= reg_wdata[11:0];
         end
         if (reg_wr && (reg_addr == `REG_PASS)) begin
            pass_r <= reg_wdata[`GEN_N-1:0];
         end
         // write-one clears, a new event in the same cycle wins
         if (reg_wr && (reg_addr == `REG_STICKY)) begin
            sticky_r <= (sticky_r & ~reg_wdata[`EN_W-1:0]) | sticky_set;
         end else begin
            sticky_r <= sticky_r | sticky_set;
         end
         if (reg_wr && (reg_addr == `REG_REQ_TX_CNT)) begin
            req_tx_cnt_r <= reg_wdata;
         end else if (inc_req_tx) begin
            req_tx_cnt_r <= req_tx_cnt_r + 32'h0000_0001;
         end
         if (reg_wr && (reg_addr == `REG_REQ_RX_CNT)) begin
            req_rx_cnt_r <= reg_wdata;
         end else if (inc_req_rx) begin
            req_rx_cnt_r <= req_rx_cnt_r + 32'h0000_0001;
         end
         if (reg_wr && (reg_addr == `REG_REP_TX_CNT)) begin
            rep_tx_cnt_r <= reg_wdata;
         end else if (inc_rep_tx) begin
            rep_tx_cnt_r <= rep_tx_cnt_r + 32'h0000_0001;
         end
         if (reg_wr && (reg_addr == `REG_REP_RX_CNT)) begin
            rep_rx_cnt_r <= reg_wdata;
         end else if (inc_rep_rx) begin
            rep_rx_cnt_r <= rep_rx_cnt_r + 32'h0000_0001;
         end
         if (reg_wr && (reg_addr == `REG_SEQ_TX_ID)) begin
            seq_tx_id_r <= reg_wdata;
         end else if (seq_ok && !lk_rx && !seq_resp) begin
            seq_tx_id_r <= seq_tx_id_r + 32'h0000_0001;
         end
         if (reg_wr && (reg_addr == `REG_SEQ_RX_ID)) begin
            seq_rx_id_r <= reg_wdata;
         end else if (seq_rx_upd) begin
            seq_rx_id_r <= lk_seq_no;
         end
         if (reg_wr && (reg_addr == `REG_SEQ_ERR_CNT)) begin
            seq_err_cnt_r <= reg_wdata;
         end else if (seq_err_nxt) begin
            seq_err_cnt_r <= seq_err_cnt_r + 32'h0000_0001;
         end
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // lookup result, one cycle after the lookup
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         res_valid      <= 1'b0;
         res_discard    <= 1'b0;
         res_ts_write   <= 1'b0;
         res_ts_field   <= `TSF_TX_FWD;
         res_ts_value   <= {`TS_W{1'b0}};
         res_extract    <= 1'b0;
         res_queue      <= {`Q_W{1'b0}};
         res_loop_reply <= 1'b0;
         res_oam_count  <= 1'b0;
         res_data_count <= 1'b0;
         res_is_msg     <= 1'b0;
         res_is_rsp     <= 1'b0;
         res_seq_write  <= 1'b0;
         res_seq_value  <= 32'h0000_0000;
         res_seq_error  <= 1'b0;
      end else if (clk_en) begin
         res_valid      <= oam_ok | seq_ok;
         res_discard    <= discard_nxt;
         res_ts_write   <= ts_write_nxt;
         res_ts_field   <= ts_field_nxt;
         res_ts_value   <= lk_timestamp;
         res_extract    <= extract_nxt;
         res_queue      <= queue_nxt;
         res_loop_reply <= loop_nxt;
         res_oam_count  <= oam_cnt_nxt;
         res_data_count <= data_cnt_nxt;
         res_is_msg     <= msg_nxt;
         res_is_rsp     <= rsp_nxt;
         res_seq_write  <= seq_write_nxt;
         res_seq_value  <= seq_tx_id_r;
         res_seq_error  <= seq_err_nxt;
      end
   end

endmodule

// File: oam_delay_generic_seq_engine_defs.vh
// Purpose: constants for the oam endpoint engine delay/generic/sequence block
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   offsets, field positions, reset values and pdu codes
`ifndef OAM_DELAY_GENERIC_SEQ_ENGINE_DEFS_VH
`define OAM_DELAY_GENERIC_SEQ_ENGINE_DEFS_VH

`define TS_W            32
`define ADDR_W          8

// register byte offsets
`define REG_CTRL        8'h00
`define REG_OAM_CNT_EN  8'h04
`define REG_DATA_CNT_EN 8'h08
`define REG_COPY_EN     8'h0C
`define REG_QUEUES      8'h10
`define REG_PASS        8'h14
`define REG_STICKY      8'h18
`define REG_REQ_TX_CNT  8'h1C
`define REG_REQ_RX_CNT  8'h20
`define REG_REP_TX_CNT  8'h24
`define REG_REP_RX_CNT  8'h28
`define REG_SEQ_TX_ID   8'h2C
`define REG_SEQ_RX_ID   8'h30
`define REG_SEQ_ERR_CNT 8'h34

// control register fields
`define CTRL_REQ_HW     0
`define CTRL_REP_HW     1
`define CTRL_ONE_HW     2
`define CTRL_LOOP       3
`define CTRL_EXT_TS     4
`define CTRL_SEQ_EN     5
`define CTRL_SEQ_RESP   6
`define CTRL_LB_TST_USE 7
`define CTRL_W          8

// per-type enable / sticky positions (count, copy and sticky layout)
`define EN_REQ          0
`define EN_REP          1
`define EN_ONE          2
`define EN_UNK          3
`define EN_LTM          4
`define EN_LTR          5
`define STK_SEQ_RX      6
`define STK_SEQ_ERR     7
`define GEN_LSB         8
`define GEN_N           8
`define EN_W            16

// queue register fields
`define Q_W             3
`define Q_GEN_LSB       0
`define Q_DEF_LSB       4
`define Q_LT_LSB        8

// reset values
`define RST_CTRL        8'h00
`define RST_EN          16'h0000
`define RST_QUEUES      12'h000
`define RST_PASS        8'h00
`define RST_CNT         32'h0000_0000

// pdu type codes on the lookup port
`define PDU_NONE        4'h0
`define PDU_REQ         4'h1
`define PDU_REP         4'h2
`define PDU_ONE         4'h3
`define PDU_LTM         4'h4
`define PDU_LTR         4'h5
`define PDU_GEN         4'h6
`define PDU_UNK         4'h7
`define PDU_SEQ         4'h8

// timestamp field selectors
`define TSF_TX_FWD      2'h0
`define TSF_RX_FWD      2'h1
`define TSF_TX_BWD      2'h2
`define TSF_RX_BWD      2'h3

`endif

// File: engine_monitor.sv
// Purpose: port checks of the oam lookup engine
// Assumes: one clock, async active-low reset, result one cycle after lookup
// Notes:   bound to the engine at the foot of this file
`include "oam_delay_generic_seq_engine_defs.vh"
module engine_monitor (
   input logic             clock,
   input logic             nrst,
   input logic             lk_valid,
   input logic             lk_rx,
   input logic [3:0]       lk_type,
   input logic             lk_same_level,
   input logic             lk_dmac_ok,
   input logic [`TS_W-1:0] lk_timestamp,
   input logic             res_valid,
   input logic             res_discard,
   input logic             res_ts_write,
   input logic [1:0]       res_ts_field,
   input logic [`TS_W-1:0] res_ts_value,
   input logic             res_loop_reply,
   input logic             res_is_msg,
   input logic             res_is_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic ok;
   assign ok = lk_valid && lk_same_level && lk_dmac_ok;
   property p_gen_quiet;
      lk_valid && lk_type inside {`PDU_GEN, `PDU_UNK} |=> !res_ts_write && !res_loop_reply;
   endproperty
   a_gen_quiet: assert property (p_gen_quiet) else $error("generic pdu modified");
   property p_lt_refused;
      lk_valid && lk_type inside {`PDU_LTM, `PDU_LTR} && !(lk_same_level && lk_dmac_ok)
         |=> !res_valid;
   endproperty
   a_lt_refused: assert property (p_lt_refused) else $error("bad link trace taken");
   property p_fwd_field;
      ok && lk_type inside {`PDU_REQ, `PDU_ONE}
         |=> !res_ts_write || res_ts_field == {1'b0, $past(lk_rx)};
   endproperty
   a_fwd_field: assert property (p_fwd_field) else $error("forward stamp field");
   property p_bwd_field;
      ok && lk_type == `PDU_REP |=> !res_ts_write || res_ts_field == {1'b1, $past(lk_rx)};
   endproperty
   a_bwd_field: assert property (p_bwd_field) else $error("backward stamp field");
   property p_ts_value;
      res_ts_write |-> res_valid && res_ts_value == $past(lk_timestamp);
   endproperty
   a_ts_value: assert property (p_ts_value) else $error("stamp value");
   property p_loop_cause;
      res_loop_reply |-> $past(ok) && $past(lk_rx) && $past(lk_type) == `PDU_REQ;
   endproperty
   a_loop_cause: assert property (p_loop_cause) else $error("reply without request");
   property p_own_level;
      ok && lk_type inside {`PDU_REQ, `PDU_REP, `PDU_ONE, `PDU_LTM, `PDU_LTR, `PDU_UNK}
         |=> res_valid && res_discard;
   endproperty
   a_own_level: assert property (p_own_level) else $error("own level pdu passed");
   property p_seq_class;
      res_is_msg || res_is_rsp |-> res_is_msg != res_is_rsp && $past(lk_type) == `PDU_SEQ;
   endproperty
   a_seq_class: assert property (p_seq_class) else $error("sequence class");
endmodule
bind oam_delay_generic_seq_engine engine_monitor engine_monitor_inst (.*);

// File: peer_endpoint_model.sv
// Purpose: far-side pipeline feeding lookups and injecting looped replies
// Assumes: pdu = {rx, type, gen, level, dmac, seq, stamp}
// Notes:   idle lookup lines toggle so stale values never look valid
`include "oam_delay_generic_seq_engine_defs.vh"
module peer_endpoint_model (
   input  logic        clock,
   input  logic        nrst,
   input  logic        send,
   input  logic [73:0] pdu,
   input  logic        loop_req,
   output logic        lk_valid,
   output logic        lk_rx,
   output logic [3:0]  lk_type,
   output logic [2:0]  lk_gen_idx,
   output logic        lk_same_level,
   output logic        lk_dmac_ok,
   output logic [31:0] lk_seq_no,
   output logic [31:0] lk_timestamp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [73:0] f;
   assign {lk_rx, lk_type, lk_gen_idx, lk_same_level, lk_dmac_ok, lk_seq_no, lk_timestamp} = f;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lk_valid <= 1'b0;
         f <= '0;
      end else if (send) begin
         lk_valid <= 1'b1;
         f <= pdu;
      end else if (loop_req) begin
         lk_valid <= 1'b1;
         f[73:64] <= {1'b0, `PDU_REP, f[68:66], 2'b11};
         f[31:0] <= f[31:0] + 32'h1;
      end else begin
         lk_valid <= 1'b0;
         f <= ~f;
      end
   end
endmodule

// File: tb.sv
// Purpose: self-checking bench for the oam lookup engine
// Assumes: result one cycle after lookup, read data one cycle after strobe
// Notes:   drivers queue expected notes, the scoreboard pops them on results
`include "oam_delay_generic_seq_engine_defs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        clk_en = 1'b1;
   logic        send = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [73:0] pdu = '0;
   logic [31:0] seed = 32'h0000_003F;
   logic [31:0] reg_rdata, lk_seq_no, lk_timestamp, res_ts_value, res_seq_value;
   logic [3:0]  lk_type;
   logic [2:0]  lk_gen_idx, res_queue;
   logic [1:0]  res_ts_field;
   logic        lk_valid, lk_rx, lk_same_level, lk_dmac_ok, res_valid, res_discard;
   logic        res_ts_write, res_extract, res_loop_reply, res_oam_count, res_data_count;
   logic        res_is_msg, res_is_rsp, res_seq_write, res_seq_error;
   logic [31:0] mr [0:13];
   logic [31:0] rq [$];
   logic [47:0] nq [$];
   logic [47:0] e;
   logic [7:0]  cfg [4] = '{8'h07, 8'h00, 8'h17, 8'h0F};
   int          bad_count = 0;
   int          tests_run = 0;
   always #2 clock = ~clock;
   oam_delay_generic_seq_engine oam_delay_generic_seq_engine_inst (.*);
   peer_endpoint_model peer_endpoint_model_inst (.*, .loop_req(res_loop_reply));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // note: {qchk, queue, field, stamp, discard, extract, loop, oam, data, msg, rsp, seqw, err, tsw}
   function logic [47:0] note(input logic rx, input logic [3:0] t, input logic [2:0] g,
                              input logic [31:0] sq, input logic [31:0] ts);
      logic [47:0] n;
      int          b;
      logic        err;
      n = '0;
      b = t == 1 ? 0 : t == 2 ? 1 : t == 3 ? 2 : t == 7 ? 3 : t < 6 ? t : 8 + g;
      if (t == `PDU_SEQ) begin
         n[4] = mr[0][6] ? rx : !rx;
         n[3] = !n[4];
         if (rx) begin
            err = sq !== mr[12] + 32'h1;
            mr[12] = sq;
            mr[6][7:6] = mr[6][7:6] | {err, 1'b1};
            mr[13] = mr[13] + err;
            n[1] = err;
            n[2] = err && mr[0][6];
         end else if (!mr[0][6]) begin
            n[2] = 1'b1;
            n[41:10] = mr[11];
            mr[11] = mr[11] + 1;
         end
         return n;
      end
      n[9] = !(t == `PDU_GEN && mr[5][g]);
      n[8] = rx && mr[3][b];
      n[7] = rx && t == `PDU_REQ && mr[0][3];
      n[6] = mr[1][b];
      n[5] = mr[2][b];
      n[0] = t < 4 && mr[0][t-1] && !mr[0][4];
      n[43:10] = {t == `PDU_REP, rx, ts};
      n[47] = n[8] && t > 3;
      n[46:44] = t == 6 ? mr[4][2:0] : t == 7 ? mr[4][6:4] : mr[4][10:8];
      if (rx) mr[6][b] = 1'b1;
      if (t < 4) mr[t == 2 ? 9 + rx : rx ? (t == 1 ? 8 : 10) : 7] += 1;
      return n;
   endfunction
   task chk(input logic [47:0] got, input logic [47:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task gap(input int n);
      send <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      send <= 1'b0;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      if (a == `REG_STICKY) mr[6] = mr[6] & ~d;
      else if (a < 8'h38) mr[a >> 2] = d;
      @(posedge clock);
   endtask
   task rd(input logic [7:0] a);
      send <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(a < 8'h38 ? mr[a >> 2] : 32'h0000_0000);
      @(posedge clock);
   endtask
   task rd_all;
      gap(3);
      for (int a = 0; a < 60; a += 4) rd(a[7:0]);
      gap(2);
   endtask
   task look(input logic rx, input logic [3:0] t, input logic [2:0] g, input logic lv,
             input logic dm, input logic [31:0] sq);
      logic [31:0] ts;
      ts = rnd();
      if (t == `PDU_SEQ ? mr[0][5] && !mr[0][7] && dm : t != 0 && lv && dm) begin
         nq.push_back(note(rx, t, g, sq, ts));
         if (nq[$][7]) nq.push_back(note(1'b0, `PDU_REP, 3'h0, sq, ~ts + 32'h1));
      end
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      send <= 1'b1;
      pdu <= {rx, t, g, lv, dm, sq, ts};
      @(posedge clock);
   endtask
   task wrap_up;
      chk(nq.size(), 48'h0, "results missing");
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      rd_d <= reg_rd;
      if (rd_d) chk({16'h0, reg_rdata}, {16'h0, rq.pop_front()}, "register");
      if (res_valid === 1'b1 && nq.size() == 0) chk(48'h1, 48'h0, "unexpected result");
      else if (res_valid === 1'b1) begin
         e = nq.pop_front();
         chk({e[47], e[47] ? res_queue : e[46:44], e[0] ? {res_ts_field, res_ts_value} :
              e[2] && !e[1] ? {2'b00, res_seq_value} : e[43:10],
              res_discard, res_extract, res_loop_reply, res_oam_count, res_data_count,
              res_is_msg, res_is_rsp, res_seq_write, res_seq_error, res_ts_write}, e, "result");
      end
   end
   initial begin
      #40000;
      bad_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial begin
      foreach (mr[i]) mr[i] = 32'h0000_0000;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      rd_all();
      wr(8'h38, 32'hFFFF_FFFF);
      wr(`REG_OAM_CNT_EN, rnd() & 32'h0000_FFFF);
      wr(`REG_DATA_CNT_EN, rnd() & 32'h0000_FFFF);
      wr(`REG_COPY_EN, rnd() & 32'h0000_FFFF);
      wr(`REG_QUEUES, 32'h0000_0653);
      wr(`REG_PASS, 32'h0000_0005);
      foreach (cfg[i]) begin
         wr(`REG_CTRL, {24'h0, cfg[i]});
         for (int t = 1; t < 8; t++) begin
            look('0, t[3:0], t[2:0], '1, '1, '0);
            look('1, t[3:0], t[2:0], '1, '1, '0);
            if (t == 1) gap(3);
         end
         rd_all();
      end
      for (int g = 0; g < 8; g++) begin
         look('1, `PDU_GEN, g[2:0], '1, '1, '0);
         look('0, `PDU_GEN, g[2:0], '1, '1, '0);
      end
      for (int t = 0; t < 8; t++) begin
         look('1, t[3:0], '0, '0, '1, '0);
         look('1, t[3:0], '0, '1, '0, '0);
      end
      wr(`REG_SEQ_TX_ID, 32'h0000_0010);
      wr(`REG_CTRL, 32'h0000_0020);
      look('0, `PDU_SEQ, '0, '0, '1, '0);
      look('0, `PDU_SEQ, '0, '1, '1, '0);
      look('1, `PDU_SEQ, '0, '1, '1, 32'h1);
      look('1, `PDU_SEQ, '0, '1, '1, 32'h7);
      wr(`REG_CTRL, 32'h0000_0060);
      look('1, `PDU_SEQ, '0, '1, '1, 32'h8);
      look('1, `PDU_SEQ, '0, '1, '1, 32'h3);
      look('0, `PDU_SEQ, '0, '1, '1, '0);
      wr(`REG_CTRL, 32'h0000_00E0);
      look('1, `PDU_SEQ, '0, '1, '1, 32'h4);
      look('0, `PDU_SEQ, '0, '1, '1, '0);
      rd_all();
      wr(`REG_STICKY, 32'h0000_FFFF);
      rd_all();
      wrap_up();
   end
endmodule
